// ### include/cpr_map.svh
// Offsets, field positions, encodings and timing counts of the core power/cache register group.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

// Register selects on the system-register access port
`define CPR_SEL_W         3
`define CPR_SEL_PSEL      3'h0
`define CPR_SEL_PWR       3'h1
`define CPR_SEL_CSSEL     3'h2
`define CPR_SEL_CTYPE     3'h3
`define CPR_SEL_CCSID     3'h4

// Exception levels
`define CPR_EL0           2'h0
`define CPR_EL2           2'h2
`define CPR_EL3           2'h3

// Power control fields
`define CPR_PWR_EV_MSB    9
`define CPR_PWR_EV_LSB    7
`define CPR_PWR_INT_MSB   6
`define CPR_PWR_INT_LSB   4
`define CPR_PWR_PD_BIT    0
`define CPR_DLY_W         3
`define CPR_DLY_OFF       3'h0
`define CPR_PWR_RST       32'h0000_0000

// Cache size select fields
`define CPR_CSS_LVL_MSB   3
`define CPR_CSS_LVL_LSB   1
`define CPR_CSS_IND_BIT   0
`define CPR_CSS_L1        3'h0
`define CPR_CSS_L2        3'h1
`define CPR_CSS_L3        3'h2
`define CPR_CSS_RSVD_MIN  4'h4

// Cache type constant fields
`define CPR_CT_RES1       1'h1
`define CPR_CT_RES0_HI    2'h0
`define CPR_CT_LOG16      4'h4
`define CPR_CT_PIPT       2'h3
`define CPR_CT_RES0_MID   10'h000

// Retention delay in system counter ticks
`define CPR_CNT_W         10
`define CPR_TICKS_1       10'h002
`define CPR_TICKS_2       10'h008
`define CPR_TICKS_3       10'h020
`define CPR_TICKS_4       10'h040
`define CPR_TICKS_5       10'h080
`define CPR_TICKS_6       10'h100
`define CPR_TICKS_7       10'h200
`define CPR_CNT_ONE       10'h001
`define CPR_CNT_ZERO      10'h000

`define CPR_WORD_ZERO     32'h0000_0000
`define CPR_SYNC_W        3

`endif

// ### include/cpr_pkg.sv
// Types of the core power/cache register group: retention states and the state record.
// Assumes cpr_map.svh on the include path.
`include "cpr_map.svh"

package cpr_pkg;

  typedef enum logic [1:0] {
    CPR_RET_IDLE  = 2'b00,
    CPR_RET_COUNT = 2'b01,
    CPR_RET_READY = 2'b11
  } cpr_ret_state_t;

  typedef struct packed {
    logic [31:0]             psel;
    logic [`CPR_DLY_W-1:0]   ev_dly;
    logic [`CPR_DLY_W-1:0]   int_dly;
    logic                    pd_en;
    logic [2:0]              css_lvl;
    logic                    css_ind;
    logic                    ack;
    logic                    deny;
    logic [31:0]             rdata;
    logic [`CPR_SYNC_W-1:0]  tick_sync;
    logic                    tick_lvl;
    logic [`CPR_SYNC_W-1:0]  bmu_sync;
    logic                    bmu_lvl;
    cpr_ret_state_t          ret_state;
    logic [`CPR_CNT_W-1:0]   cnt;
    logic                    wait_prev;
    logic                    pact_ret;
    logic                    pact_pd;
    logic                    ret_acc;
    logic                    ret_ref;
  } cpr_state_t;

endpackage

// ### src/cpr_sysregs.sv
// Core power control and cache identification system registers with retention timing.
// Assumes a same-clock access port from the core, wait states from core logic, and
// system counter tick and broadcast pin arriving from outside this clock.
//
// Notes on behaviour
// - Private selection: 32 reserved bits, Secure only.
// - Private selection reachable only from highest level.
// - Event-wait delay field, zero disables retention.
// - Interrupt-wait delay field, same encoding, zero disables.
// - Delay codes map to 2 through 512 ticks.
// - Retention ready after ticks; earlier requests refused.
// - Power-down enable requests power-down in interrupt wait.
// - Lower-level writes gated by auxiliary bit 7.
// - Power control RW at privileged levels, not EL0.
// - Cache select level field picks L1 or L2; L3 codes fall in the reserved range.
// - Instruction bit selects instruction or data cache.
// - L2 instruction and codes 0100-1111 are reserved.
// - Missing cache level reads an unknown size value.
// - Cache type read-only, bit31 one, 30:29 zero.
// - Coherence-clean flag is inverse of broadcast pin.
// - Flag zero means clean needed, one means not.
// - Write-back granule reports 16 words.
// - Exclusive granule reports 16 words.
// - Smallest data line reports 16 words.
// - Instruction cache policy reports physically indexed, tagged.
// - Smallest instruction line 16 words; 13:4 zero.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"

module cpr_sysregs
  import cpr_pkg::*;
#(
  parameter bit L3_PRESENT = 1'b1
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   req_i,
  input  wire logic                   write_i,
  input  wire logic [`CPR_SEL_W-1:0]  sel_i,
  input  wire logic [1:0]             el_i,
  input  wire logic                   ns_i,
  input  wire logic [31:0]            wdata_i,
  input  wire logic                   aux_l2_wr_en_i,
  input  wire logic                   aux_l3_wr_en_i,
  input  wire logic [31:0]            ccsid_data_i,
  input  wire logic                   wfi_state_i,
  input  wire logic                   wfe_state_i,
  input  wire logic                   sys_tick_i,
  input  wire logic                   ret_req_i,
  input  wire logic                   bcast_maint_pin_i,
  output logic                        ack_o,
  output logic                        deny_o,
  output logic [31:0]                 rdata_o,
  output logic                        pactive_ret_o,
  output logic                        pactive_pd_o,
  output logic                        ret_accept_o,
  output logic                        ret_refuse_o
);

  if ($bits(ccsid_data_i) != 32) begin : g_bad_width
    $error("cache size word must be 32 bits");
  end

  cpr_state_t s_reg;
  cpr_state_t s_next;

  function automatic logic [`CPR_CNT_W-1:0] dly_ticks(input logic [`CPR_DLY_W-1:0] code);
    logic [`CPR_CNT_W-1:0] t;
    t = `CPR_CNT_ZERO;
    unique case (code)
      3'h1:    t = `CPR_TICKS_1;
      3'h2:    t = `CPR_TICKS_2;
      3'h3:    t = `CPR_TICKS_3;
      3'h4:    t = `CPR_TICKS_4;
      3'h5:    t = `CPR_TICKS_5;
      3'h6:    t = `CPR_TICKS_6;
      3'h7:    t = `CPR_TICKS_7;
      default: t = `CPR_CNT_ZERO;
    endcase
    return t;
  endfunction

  logic                   wait_now;
  logic                   wait_entry;
  logic                   tick_evt;
  logic                   tick_lvl_n;
  logic                   bmu_lvl_n;
  logic [`CPR_DLY_W-1:0]  cur_dly;
  logic [`CPR_CNT_W-1:0]  target;
  logic                   rd_ok;
  logic                   wr_ok;
  logic                   css_rsvd;
  logic                   lvl_present;
  logic [31:0]            ctype_word;
  logic [31:0]            pwr_word;
  logic [31:0]            css_word;
  logic [31:0]            rd_word;

  always_comb begin
    s_next = s_reg;

    // Change is taken only once second and third stages agree
    s_next.tick_sync = {s_reg.tick_sync[1:0], sys_tick_i};
    s_next.bmu_sync  = {s_reg.bmu_sync[1:0], bcast_maint_pin_i};
    tick_lvl_n = (s_reg.tick_sync[1] == s_reg.tick_sync[2]) ? s_reg.tick_sync[2] : s_reg.tick_lvl;
    bmu_lvl_n  = (s_reg.bmu_sync[1] == s_reg.bmu_sync[2]) ? s_reg.bmu_sync[2] : s_reg.bmu_lvl;
    s_next.tick_lvl = tick_lvl_n;
    s_next.bmu_lvl  = bmu_lvl_n;
    tick_evt = tick_lvl_n & ~s_reg.tick_lvl;

    ctype_word = {`CPR_CT_RES1, `CPR_CT_RES0_HI,
                  ~s_reg.bmu_lvl,
                  `CPR_CT_LOG16,
                  `CPR_CT_LOG16,
                  `CPR_CT_LOG16,
                  `CPR_CT_PIPT,
                  `CPR_CT_RES0_MID, `CPR_CT_LOG16};

    pwr_word = `CPR_WORD_ZERO;
    pwr_word[`CPR_PWR_EV_MSB:`CPR_PWR_EV_LSB]   = s_reg.ev_dly;
    pwr_word[`CPR_PWR_INT_MSB:`CPR_PWR_INT_LSB] = s_reg.int_dly;
    pwr_word[`CPR_PWR_PD_BIT]                   = s_reg.pd_en;
    css_word = `CPR_WORD_ZERO;
    css_word[`CPR_CSS_LVL_MSB:`CPR_CSS_LVL_LSB] = s_reg.css_lvl;
    css_word[`CPR_CSS_IND_BIT]                  = s_reg.css_ind;

    css_rsvd = ({wdata_i[`CPR_CSS_LVL_MSB:`CPR_CSS_LVL_LSB], wdata_i[`CPR_CSS_IND_BIT]}
                >= `CPR_CSS_RSVD_MIN)
               || (wdata_i[`CPR_CSS_LVL_MSB:`CPR_CSS_LVL_LSB] == `CPR_CSS_L2
                   && wdata_i[`CPR_CSS_IND_BIT]);
    lvl_present = (s_reg.css_lvl == `CPR_CSS_L1) || (s_reg.css_lvl == `CPR_CSS_L2)
                  || ((s_reg.css_lvl == `CPR_CSS_L3) && L3_PRESENT);

    rd_ok = 1'b0;
    wr_ok = 1'b0;
    rd_word = `CPR_WORD_ZERO;
    unique case (sel_i)
      `CPR_SEL_PSEL: begin
        rd_ok = (el_i == `CPR_EL3) && !ns_i;
        wr_ok = rd_ok;
        rd_word = s_reg.psel;
      end
      `CPR_SEL_PWR: begin
        rd_ok = (el_i != `CPR_EL0);
        if (el_i == `CPR_EL3) begin
          wr_ok = 1'b1;
        end else if (el_i == `CPR_EL2) begin
          wr_ok = aux_l3_wr_en_i;
        end else begin
          wr_ok = rd_ok && aux_l3_wr_en_i && (aux_l2_wr_en_i || !ns_i);
        end
        rd_word = pwr_word;
      end
      `CPR_SEL_CSSEL: begin
        rd_ok = (el_i != `CPR_EL0);
        wr_ok = rd_ok;
        rd_word = css_word;
      end
      `CPR_SEL_CTYPE: begin
        rd_ok = 1'b1;
        rd_word = ctype_word;
      end
      `CPR_SEL_CCSID: begin
        rd_ok = (el_i != `CPR_EL0);
        // Unknown value for a missing level is returned as zero
        rd_word = lvl_present ? ccsid_data_i : `CPR_WORD_ZERO;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase

    s_next.ack  = req_i;
    s_next.deny = req_i && (write_i ? !wr_ok : !rd_ok);
    s_next.rdata = (req_i && !write_i && rd_ok) ? rd_word : `CPR_WORD_ZERO;
    if (req_i && write_i && wr_ok) begin
      unique case (sel_i)
        `CPR_SEL_PSEL: begin
          s_next.psel = wdata_i;
        end
        `CPR_SEL_PWR: begin
          s_next.ev_dly  = wdata_i[`CPR_PWR_EV_MSB:`CPR_PWR_EV_LSB];
          s_next.int_dly = wdata_i[`CPR_PWR_INT_MSB:`CPR_PWR_INT_LSB];
          s_next.pd_en   = wdata_i[`CPR_PWR_PD_BIT];
        end
        `CPR_SEL_CSSEL: begin
          // Reserved combinations leave the selection as it was
          if (!css_rsvd) begin
            s_next.css_lvl = wdata_i[`CPR_CSS_LVL_MSB:`CPR_CSS_LVL_LSB];
            s_next.css_ind = wdata_i[`CPR_CSS_IND_BIT];
          end
        end
        default: begin
          s_next.psel = s_reg.psel;
        end
      endcase
    end

    // Retention timing; interrupt wait takes the interrupt-wait field
    wait_now   = wfi_state_i | wfe_state_i;
    wait_entry = wait_now & ~s_reg.wait_prev;
    cur_dly    = wfi_state_i ? s_reg.int_dly : s_reg.ev_dly;
    target     = dly_ticks(cur_dly);
    s_next.wait_prev = wait_now;
    unique case (s_reg.ret_state)
      CPR_RET_IDLE: begin
        if (wait_entry && cur_dly != `CPR_DLY_OFF) begin
          s_next.ret_state = CPR_RET_COUNT;
          s_next.cnt = `CPR_CNT_ZERO;
        end
      end
      CPR_RET_COUNT: begin
        if (!wait_now || cur_dly == `CPR_DLY_OFF) begin
          s_next.ret_state = CPR_RET_IDLE;
          s_next.cnt = `CPR_CNT_ZERO;
        end else if (tick_evt) begin
          s_next.cnt = s_reg.cnt + `CPR_CNT_ONE;
          if ((s_reg.cnt + `CPR_CNT_ONE) >= target) begin
            s_next.ret_state = CPR_RET_READY;
          end
        end
      end
      CPR_RET_READY: begin
        if (!wait_now) begin
          s_next.ret_state = CPR_RET_IDLE;
          s_next.cnt = `CPR_CNT_ZERO;
        end
      end
      default: begin
        s_next.ret_state = CPR_RET_IDLE;
      end
    endcase
    s_next.pact_ret = (s_next.ret_state == CPR_RET_READY);
    s_next.ret_acc  = ret_req_i && (s_reg.ret_state == CPR_RET_READY);
    s_next.ret_ref  = ret_req_i && (s_reg.ret_state != CPR_RET_READY);
    s_next.pact_pd  = s_next.pd_en && wfi_state_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.ret_state <= CPR_RET_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ack_o         = s_reg.ack;
  assign deny_o        = s_reg.deny;
  assign rdata_o       = s_reg.rdata;
  assign pactive_ret_o = s_reg.pact_ret;
  assign pactive_pd_o  = s_reg.pact_pd;
  assign ret_accept_o  = s_reg.ret_acc;
  assign ret_refuse_o  = s_reg.ret_ref;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence psel_low_req;
    req_i && sel_i == `CPR_SEL_PSEL && (el_i != `CPR_EL3 || ns_i);
  endsequence
  sequence denied_answer;
    ack_o && deny_o && rdata_o == `CPR_WORD_ZERO;
  endsequence

  a_psel_low_deny: assert property (psel_low_req |=> denied_answer)
    else $error("private selection reached below top level");

  a_pwr_el0_deny: assert property (
    req_i && sel_i == `CPR_SEL_PWR && el_i == `CPR_EL0 |=> denied_answer)
    else $error("power control reached from EL0");

  a_pwr_el2_gate: assert property (
    req_i && write_i && sel_i == `CPR_SEL_PWR && el_i == `CPR_EL2 && !aux_l3_wr_en_i
    |=> deny_o ##0 $stable(s_reg.pd_en))
    else $error("gated power control write took effect");

  a_ctype_fixed: assert property (
    req_i && !write_i && sel_i == `CPR_SEL_CTYPE
    |=> rdata_o[31:29] == 3'h4 && rdata_o[27:0] == 28'h444C004 && !deny_o)
    else $error("cache type constant fields wrong");

  a_ctype_idc: assert property (
    req_i && !write_i && sel_i == `CPR_SEL_CTYPE |=> rdata_o[28] == !$past(s_reg.bmu_lvl))
    else $error("coherence flag not inverse of pin");

  a_css_rsvd_keep: assert property (
    req_i && write_i && sel_i == `CPR_SEL_CSSEL && wdata_i[3:0] >= 4'h4
    |=> $stable(s_reg.css_lvl) && $stable(s_reg.css_ind))
    else $error("reserved cache selection was stored");

  a_css_l2_inst: assert property (
    req_i && write_i && sel_i == `CPR_SEL_CSSEL && wdata_i[`CPR_CSS_LVL_MSB:`CPR_CSS_LVL_LSB] == `CPR_CSS_L2
    && wdata_i[`CPR_CSS_IND_BIT] |=> $stable(s_reg.css_lvl) && $stable(s_reg.css_ind))
    else $error("level two instruction selection was stored");

  a_pwr_rsvd_zero: assert property (
    req_i && !write_i && sel_i == `CPR_SEL_PWR |=> rdata_o[31:10] == 22'h0 && rdata_o[3:1] == 3'h0)
    else $error("power control reserved bits not zero");

  a_psel_grant: assert property (
    req_i && sel_i == `CPR_SEL_PSEL && el_i == `CPR_EL3 && !ns_i |=> ack_o && !deny_o)
    else $error("private selection refused at secure top level");

  a_ret_refuse: assert property (
    ret_req_i && s_reg.ret_state != CPR_RET_READY |=> ret_refuse_o && !ret_accept_o)
    else $error("retention accepted before delay");

  a_ret_accept: assert property (
    ret_req_i && s_reg.ret_state == CPR_RET_READY |=> ret_accept_o && !ret_refuse_o)
    else $error("retention request refused while ready");

  // Field may be rewritten while ready, so only the entry into ready is checked
  a_ret_ticks: assert property (
    $rose(pactive_ret_o) |-> s_reg.cnt >= $past(target))
    else $error("retention ready before tick count");

  a_ret_restart: assert property (
    s_reg.ret_state == CPR_RET_IDLE && wait_entry && cur_dly != `CPR_DLY_OFF
    |=> s_reg.cnt == `CPR_CNT_ZERO && s_reg.ret_state == CPR_RET_COUNT)
    else $error("retention count did not restart");

  a_ret_drop: assert property (
    s_reg.ret_state == CPR_RET_READY && !wait_now |=> !pactive_ret_o)
    else $error("readiness held after wait state ended");

  a_ret_off: assert property (
    wait_entry && cur_dly == `CPR_DLY_OFF && s_reg.ret_state == CPR_RET_IDLE
    |=> !pactive_ret_o [*2])
    else $error("retention armed while disabled");

  a_pd_request: assert property (
    s_reg.pd_en && wfi_state_i && !(req_i && write_i) |=> pactive_pd_o)
    else $error("power-down request missing");

  a_pd_release: assert property (
    !wfi_state_i |=> !pactive_pd_o)
    else $error("power-down request without interrupt wait");

endmodule

`default_nettype wire

// ### dv/cpr_pwr_ctrl_model.sv
// Power controller stand-in: raises retention entry requests and records the answers.
// Assumes the register block's clock, reset and retention handshake ports.
`timescale 1ns/1ps
`default_nettype none
module cpr_pwr_ctrl_model (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic ask_i,
  input  wire logic pactive_ret_i,
  input  wire logic ret_accept_i,
  input  wire logic ret_refuse_i,
  output logic      ret_req_o,
  output logic      got_accept_o,
  output logic      got_refuse_o,
  output logic      bad_accept_o
);
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ret_req_o    <= 1'b0;
      got_accept_o <= 1'b0;
      got_refuse_o <= 1'b0;
      bad_accept_o <= 1'b0;
    end else begin
      ret_req_o <= ask_i;
      if (ask_i) begin
        got_accept_o <= 1'b0;
        got_refuse_o <= 1'b0;
      end
      if (ret_accept_i) got_accept_o <= 1'b1;
      if (ret_refuse_i) got_refuse_o <= 1'b1;
      // Sticky, so a single early grant is never missed
      if (ret_accept_i && !pactive_ret_i) bad_accept_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the core power/cache register group.
// Assumes cpr_pkg and cpr_map.svh compiled first; power controller model on the far side.
`timescale 1ns/1ps
`default_nettype none
`include "cpr_map.svh"
module testbench;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_i = 1'b0, write_i = 1'b0, ns_i = 1'b0, aux2 = 1'b0, aux3 = 1'b0;
  logic [2:0] sel_i = 3'h0;
  logic [1:0] el_i = 2'h0;
  logic [31:0] wdata_i = 32'h0, ccsid = 32'h1234_5678;
  logic wait_for_interrupt_state = 1'b0, wait_for_event_state = 1'b0, tick = 1'b0, bmu = 1'b0, ask = 1'b0;
  logic ack, deny, p_ret, p_pd, acc, refu, ret_req, g_acc, g_ref, bad;
  logic [31:0] rdata;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  int ticks [7] = '{2, 8, 32, 64, 128, 256, 512};

  always #12.5 sys_clk_i = ~sys_clk_i;

  cpr_sysregs DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_i(req_i), .write_i(write_i),
    .sel_i(sel_i), .el_i(el_i), .ns_i(ns_i), .wdata_i(wdata_i), .aux_l2_wr_en_i(aux2),
    .aux_l3_wr_en_i(aux3), .ccsid_data_i(ccsid), .wfi_state_i(wait_for_interrupt_state), .wfe_state_i(wait_for_event_state),
    .sys_tick_i(tick), .ret_req_i(ret_req), .bcast_maint_pin_i(bmu), .ack_o(ack), .deny_o(deny),
    .rdata_o(rdata), .pactive_ret_o(p_ret), .pactive_pd_o(p_pd), .ret_accept_o(acc),
    .ret_refuse_o(refu));

  cpr_pwr_ctrl_model u_pwr (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ask_i(ask),
    .pactive_ret_i(p_ret), .ret_accept_i(acc), .ret_refuse_i(refu), .ret_req_o(ret_req),
    .got_accept_o(g_acc), .got_refuse_o(g_ref), .bad_accept_o(bad));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One access; ack stands a full cycle, so the next falling edge sees it
  task automatic acc_reg(input logic wr, input logic [2:0] s, input logic [1:0] e, input logic n,
                         input logic [31:0] wd, input logic exp_deny, input logic [31:0] exp_rd);
    @(negedge sys_clk_i);
    req_i = 1'b1; write_i = wr; sel_i = s; el_i = e; ns_i = n; wdata_i = wd;
    @(negedge sys_clk_i);
    req_i = 1'b0;
    chk({31'h0, ack}, 32'h1, "ack");
    chk({31'h0, deny}, {31'h0, exp_deny}, "deny");
    if (!wr) chk(rdata, exp_rd, "read data");
  endtask

  task automatic send_ticks(input int n);
    repeat (n) begin
      @(negedge sys_clk_i) tick = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      tick = 1'b0;
      repeat (3) @(negedge sys_clk_i);
    end
    repeat (8) @(negedge sys_clk_i);
  endtask

  task automatic ask_ret(input logic exp_acc);
    @(negedge sys_clk_i) ask = 1'b1;
    @(negedge sys_clk_i) ask = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk({30'h0, g_acc, g_ref}, exp_acc ? 32'h2 : 32'h1, "retention answer");
  endtask

  task automatic test_done(input string name);
    $display("Test %s finished, mismatches so far %0d", name, miscompares);
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      $display("MISMATCH t=%0t run exceeded cycle ceiling", $time);
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    // Identification word, both pin levels, write refused
    acc_reg(1'b0, `CPR_SEL_CTYPE, 2'h0, 1'b1, 32'h0, 1'b0, 32'h9444_C004);
    bmu = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    acc_reg(1'b0, `CPR_SEL_CTYPE, 2'h0, 1'b1, 32'h0, 1'b0, 32'h8444_C004);
    acc_reg(1'b1, `CPR_SEL_CTYPE, 2'h3, 1'b0, 32'h0, 1'b1, 32'h0);
    test_done("cache_type");
    // Private selection: secure top level only
    acc_reg(1'b1, `CPR_SEL_PSEL, 2'h3, 1'b0, 32'hA5C3_0F96, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_PSEL, 2'h3, 1'b0, 32'h0, 1'b0, 32'hA5C3_0F96);
    acc_reg(1'b0, `CPR_SEL_PSEL, 2'h3, 1'b1, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b1, `CPR_SEL_PSEL, 2'h1, 1'b0, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b0, `CPR_SEL_PSEL, 2'h2, 1'b1, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b0, `CPR_SEL_PSEL, 2'h3, 1'b0, 32'h0, 1'b0, 32'hA5C3_0F96);
    test_done("private_selection");
    // Power control: reset value, reserved bits, level gating
    acc_reg(1'b0, `CPR_SEL_PWR, 2'h1, 1'b0, 32'h0, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_PWR, 2'h0, 1'b0, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b1, `CPR_SEL_PWR, 2'h3, 1'b0, 32'hFFFF_FFFF, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_PWR, 2'h3, 1'b0, 32'h0, 1'b0, 32'h0000_03F1);
    acc_reg(1'b1, `CPR_SEL_PWR, 2'h2, 1'b1, 32'h0, 1'b1, 32'h0);
    aux3 = 1'b1;
    acc_reg(1'b1, `CPR_SEL_PWR, 2'h1, 1'b1, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b1, `CPR_SEL_PWR, 2'h2, 1'b1, 32'h0000_0080, 1'b0, 32'h0);
    aux2 = 1'b1;
    acc_reg(1'b1, `CPR_SEL_PWR, 2'h1, 1'b1, 32'h0000_0001, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_PWR, 2'h1, 1'b1, 32'h0, 1'b0, 32'h0000_0001);
    wait_for_interrupt_state = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk({31'h0, p_pd}, 32'h1, "powerdown request");
    wait_for_interrupt_state = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk({31'h0, p_pd}, 32'h0, "powerdown released");
    test_done("power_control");
    // Cache select: legal codes kept, reserved codes ignored
    acc_reg(1'b1, `CPR_SEL_CSSEL, 2'h1, 1'b0, 32'hFFFF_FFF2, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_CSSEL, 2'h1, 1'b0, 32'h0, 1'b0, 32'h0000_0002);
    acc_reg(1'b1, `CPR_SEL_CSSEL, 2'h1, 1'b0, 32'h0000_0003, 1'b0, 32'h0);
    acc_reg(1'b1, `CPR_SEL_CSSEL, 2'h1, 1'b0, 32'h0000_0009, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_CSSEL, 2'h2, 1'b0, 32'h0, 1'b0, 32'h0000_0002);
    acc_reg(1'b1, `CPR_SEL_CSSEL, 2'h1, 1'b0, 32'h0000_0001, 1'b0, 32'h0);
    acc_reg(1'b0, `CPR_SEL_CSSEL, 2'h1, 1'b0, 32'h0, 1'b0, 32'h0000_0001);
    acc_reg(1'b0, `CPR_SEL_CSSEL, 2'h0, 1'b0, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b0, `CPR_SEL_CCSID, 2'h1, 1'b0, 32'h0, 1'b0, 32'h1234_5678);
    acc_reg(1'b1, `CPR_SEL_CCSID, 2'h1, 1'b0, 32'h0, 1'b1, 32'h0);
    acc_reg(1'b0, 3'h5, 2'h3, 1'b0, 32'h0, 1'b1, 32'h0);
    test_done("cache_select");
    // Every interrupt-wait delay code, refused one tick short
    for (int c = 1; c < 8; c++) begin
      acc_reg(1'b1, `CPR_SEL_PWR, 2'h3, 1'b0, 32'(c) << 4, 1'b0, 32'h0);
      wait_for_interrupt_state = 1'b1;
      send_ticks(ticks[c-1] - 1);
      chk({31'h0, p_ret}, 32'h0, "early readiness");
      ask_ret(1'b0);
      send_ticks(1);
      chk({31'h0, p_ret}, 32'h1, "readiness");
      ask_ret(1'b1);
      wait_for_interrupt_state = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      chk({31'h0, p_ret}, 32'h0, "readiness dropped");
    end
    // Event field only: interrupt wait must not count, event wait restarts on re-entry
    acc_reg(1'b1, `CPR_SEL_PWR, 2'h3, 1'b0, 32'h0000_0080, 1'b0, 32'h0);
    wait_for_interrupt_state = 1'b1;
    send_ticks(3);
    chk({31'h0, p_ret}, 32'h0, "disabled field");
    wait_for_interrupt_state = 1'b0;
    @(negedge sys_clk_i) wait_for_event_state = 1'b1;
    send_ticks(1);
    wait_for_event_state = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    wait_for_event_state = 1'b1;
    send_ticks(1);
    chk({31'h0, p_ret}, 32'h0, "count restarted");
    send_ticks(1);
    chk({31'h0, p_ret}, 32'h1, "event readiness");
    chk({31'h0, bad}, 32'h0, "grant before readiness");
    wait_for_event_state = 1'b0;
    test_done("retention");
    end_of_test();
  end
endmodule
`default_nettype wire
